// >>> bfi_pkg.sv
// Constants and carrier types for the byte-flow status bank 0 block
package bfi_pkg;
  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam int unsigned AW = 3;
  localparam logic [AW-1:0] ADDR_STATUS0 = 3'h0; // Read side
  localparam logic [AW-1:0] ADDR_MASK0   = 3'h0; // Write side
  localparam logic [AW-1:0] ADDR_DATA    = 3'h1;
  localparam logic [AW-1:0] ADDR_AUXCTL  = 3'h2;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_MAC  = 0;
  localparam int unsigned BIT_RLC  = 1;
  localparam int unsigned BIT_SERIAL_POLL_ACTIVE_FLAG = 2;
  localparam int unsigned BIT_END  = 3;
  localparam int unsigned BIT_BO   = 4;
  localparam int unsigned BIT_BI   = 5;
  localparam int unsigned BIT_SUM1 = 6;  // Read: bank 1 summary
  localparam int unsigned BIT_SUM0 = 7;  // Read: bank 0 summary
  localparam int unsigned BIT_LDMA = 6;  // Write: listener DMA enable
  localparam int unsigned BIT_TDMA = 7;  // Write: talker DMA enable
  localparam int unsigned AUX_DMA_MASTER_ENABLE = 0;
  localparam int unsigned AUX_CONT = 1;
  localparam int unsigned AUX_SWRST = 2;
  localparam int unsigned AUX_HOLD = 3;
  localparam int unsigned AUX_NBA  = 4;
  localparam int unsigned AUX_FULL = 5;
  localparam int unsigned NFLAG    = 6;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]       MASK_RST = 8'h00;
  localparam logic [NFLAG-1:0] FLAG_RST = 6'h00;
  localparam logic [7:0]       BYTE_RST = 8'h00;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic lacs;
    logic acds;
    logic cacs;
    logic tacs;
    logic sgns;
  } bfi_hs_type;
  typedef struct packed {
    logic end_rx;
    logic serial_poll_active_flag;
    logic remote_local_change_flag;
    logic mac;
  } bfi_evt_type;
endpackage

// >>> bfi_status_bank0.sv
// Status/mask bank 0 with byte flow, DMA request and interrupt summary
//
// Overview of operation
// - Reading status register clears its six flag bits
// - Six enables gate conditions onto interrupt
// - Mask never alters recorded status bits
// - Events during status read set afterwards
// - Hardware reset clears whole mask register
// - Bit 7 read: any enabled bank0 bit
// - Bit 6 read: any enabled bank1 bit
// - Talker DMA requests when outgoing register free
// - No talker DMA request unless addressed talker
// - Listener DMA requests while incoming byte held
// - Byte-in sets on listener data accepted while cont_r is clear
// - Byte-in clears: swrst, status read, data read
// - Next byte waits for holdoff release
// - Byte-out sets: active, generate, nothing pending
// - Byte-out sets again after each byte
// - Byte-out clears: swrst, status read, data write
// - Capture bus byte on listener data accepted
// - Address-change bit reports addressed state change
//
// Design decisions made here: the register offsets and the strobed register port.
module bfi_status_bank0 (
  input  wire logic                 CORE_CLK,
  input  wire logic                 RST_N,
  input  wire logic [bfi_pkg::AW-1:0] ADDR,
  input  wire logic [7:0]           WDATA,
  input  wire logic                 WR,
  input  wire logic                 RD,
  output logic      [7:0]           RDATA,
  input  wire bfi_pkg::bfi_hs_type  HS,
  input  wire bfi_pkg::bfi_evt_type EVT,
  input  wire logic [7:0]           DIO_IN,
  input  wire logic                 OUT_TAKEN,
  input  wire logic                 IRQ_STATUS_1_ANY,
  output logic      [7:0]           OUT_DATA,
  output logic                      OUT_VALID,
  output logic                      RFD_HOLDOFF,
  output logic                      IRQ,
  output logic                      DMA_REQUEST_N
);
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic stb,
                               input logic [bfi_pkg::AW-1:0] a,
                               input logic [bfi_pkg::AW-1:0] t);
    hit = stb & (a == t);
  endfunction

  logic [7:0]                irq_enable_mask_0_r, mask_nxt;
  logic [bfi_pkg::NFLAG-1:0] flags_r, flags_nxt;
  logic [bfi_pkg::NFLAG-1:0] pend_r, pend_nxt;
  logic [bfi_pkg::NFLAG-1:0] set_v, clr_v;
  logic [7:0]                din_r, din_nxt;
  logic [7:0]                dout_r, dout_nxt;
  logic [7:0]                rdata_r, rdata_nxt;
  logic                      dma_master_enable_r, dma_master_enable_nxt;
  logic                      cont_r, cont_nxt;
  logic                      hold_r, hold_nxt;
  logic                      full_r, full_nxt;
  logic                      nba_r, nba_nxt;
  logic                      bi_cond_r, bo_cond_r;
  logic                      bi_cond, bo_cond;
  logic                      dma_r, dma_nxt;
  logic                      irq_r, irq_nxt;
  logic                      rd_stat, rd_data, rd_aux;
  logic                      wr_mask, wr_data, wr_aux;
  logic                      swrst, capture, sum0;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    rd_stat = hit(RD, ADDR, bfi_pkg::ADDR_STATUS0);
    rd_data = hit(RD, ADDR, bfi_pkg::ADDR_DATA);
    rd_aux  = hit(RD, ADDR, bfi_pkg::ADDR_AUXCTL);
    wr_mask = hit(WR, ADDR, bfi_pkg::ADDR_MASK0);
    wr_data = hit(WR, ADDR, bfi_pkg::ADDR_DATA);
    wr_aux  = hit(WR, ADDR, bfi_pkg::ADDR_AUXCTL);
    swrst   = wr_aux & WDATA[bfi_pkg::AUX_SWRST];

    mask_nxt = wr_mask ? WDATA : irq_enable_mask_0_r;
    dma_master_enable_nxt = wr_aux ? WDATA[bfi_pkg::AUX_DMA_MASTER_ENABLE] : dma_master_enable_r;
    cont_nxt = wr_aux ? WDATA[bfi_pkg::AUX_CONT] : cont_r;

    // Edge of the handshake state so one byte gives one capture
    bi_cond = HS.lacs & HS.acds;
    capture = bi_cond & ~bi_cond_r & ~hold_r;
    bo_cond = (HS.cacs | HS.tacs) & HS.sgns & ~nba_r;

    set_v = '0;
    set_v[bfi_pkg::BIT_BI]   = capture & ~cont_r;
    set_v[bfi_pkg::BIT_BO]   = bo_cond & ~bo_cond_r;
    set_v[bfi_pkg::BIT_END]  = EVT.end_rx;
    set_v[bfi_pkg::BIT_SERIAL_POLL_ACTIVE_FLAG] = EVT.serial_poll_active_flag;
    set_v[bfi_pkg::BIT_RLC]  = EVT.remote_local_change_flag;
    set_v[bfi_pkg::BIT_MAC]  = EVT.mac;

    clr_v = {bfi_pkg::NFLAG{rd_stat | swrst}};
    clr_v[bfi_pkg::BIT_BI] = rd_stat | swrst | rd_data;
    clr_v[bfi_pkg::BIT_BO] = rd_stat | swrst | wr_data;

    // Sets never lost: during a status read they wait in pend_r until the first cycle with no status read
    if (rd_stat) begin
      flags_nxt = flags_r & ~clr_v;
      pend_nxt  = set_v | pend_r;
    end else begin
      flags_nxt = (flags_r & ~clr_v) | set_v | pend_r;
      pend_nxt  = '0;
    end

    din_nxt  = capture ? DIO_IN : din_r;
    hold_nxt = (capture & ~cont_r) | (hold_r & ~rd_data);
    full_nxt = capture | (full_r & ~rd_data);
    dout_nxt = wr_data ? WDATA : dout_r;
    nba_nxt  = wr_data | (nba_r & ~OUT_TAKEN);

    // Talker path gated by addressed talker state
    dma_nxt = dma_master_enable_r & ((irq_enable_mask_0_r[bfi_pkg::BIT_TDMA] & HS.tacs
                         & ~nba_r & ~wr_data)
                      | (irq_enable_mask_0_r[bfi_pkg::BIT_LDMA]
                         & full_r & ~rd_data));

    sum0    = |(flags_r & irq_enable_mask_0_r[bfi_pkg::NFLAG-1:0]);
    irq_nxt = (|(flags_nxt & mask_nxt[bfi_pkg::NFLAG-1:0])) | IRQ_STATUS_1_ANY;

    rdata_nxt = bfi_pkg::BYTE_RST;
    if (rd_stat) begin
      rdata_nxt = {sum0, IRQ_STATUS_1_ANY, flags_r};
    end else if (rd_data) begin
      rdata_nxt = din_r;
    end else if (rd_aux) begin
      rdata_nxt[bfi_pkg::AUX_DMA_MASTER_ENABLE] = dma_master_enable_r;
      rdata_nxt[bfi_pkg::AUX_CONT] = cont_r;
      rdata_nxt[bfi_pkg::AUX_HOLD] = hold_r;
      rdata_nxt[bfi_pkg::AUX_NBA]  = nba_r;
      rdata_nxt[bfi_pkg::AUX_FULL] = full_r;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_enable_mask_0_r <= bfi_pkg::MASK_RST;
      flags_r   <= bfi_pkg::FLAG_RST;
      pend_r    <= bfi_pkg::FLAG_RST;
      din_r     <= bfi_pkg::BYTE_RST;
      dout_r    <= bfi_pkg::BYTE_RST;
      rdata_r   <= bfi_pkg::BYTE_RST;
      dma_master_enable_r    <= 1'b0;
      cont_r    <= 1'b0;
      hold_r    <= 1'b0;
      full_r    <= 1'b0;
      nba_r     <= 1'b0;
      bi_cond_r <= 1'b0;
      bo_cond_r <= 1'b0;
      dma_r     <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      irq_enable_mask_0_r <= mask_nxt;
      flags_r   <= flags_nxt;
      pend_r    <= pend_nxt;
      din_r     <= din_nxt;
      dout_r    <= dout_nxt;
      rdata_r   <= rdata_nxt;
      dma_master_enable_r    <= dma_master_enable_nxt;
      cont_r    <= cont_nxt;
      hold_r    <= hold_nxt;
      full_r    <= full_nxt;
      nba_r     <= nba_nxt;
      bi_cond_r <= bi_cond;
      bo_cond_r <= bo_cond;
      dma_r     <= dma_nxt;
      irq_r     <= irq_nxt;
    end
  end

  assign RDATA         = rdata_r;
  assign OUT_DATA      = dout_r;
  assign OUT_VALID     = nba_r;
  assign RFD_HOLDOFF   = hold_r;
  assign IRQ           = irq_r;
  assign DMA_REQUEST_N = ~dma_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_read_clears;
    @(posedge CORE_CLK) disable iff (!RST_N)
    rd_stat |=> flags_r == '0;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status read did not clear flags");

  property p_set_deferred;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (rd_stat && set_v != '0) ##1 !rd_stat
      |=> (flags_r & $past(set_v, 2)) == $past(set_v, 2);
  endproperty
  a_set_deferred: assert property (p_set_deferred)
    else $error("event during status read was lost");

  property p_mask_free;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (!rd_stat && set_v != '0) |=> (flags_r & $past(set_v)) == $past(set_v);
  endproperty
  a_mask_free: assert property (p_mask_free)
    else $error("status set blocked");

  property p_sum0;
    @(posedge CORE_CLK) disable iff (!RST_N)
    rd_stat |=> RDATA[bfi_pkg::BIT_SUM0]
      == (|($past(flags_r) & $past(irq_enable_mask_0_r[bfi_pkg::NFLAG-1:0])));
  endproperty
  a_sum0: assert property (p_sum0)
    else $error("bank 0 summary wrong");

  property p_sum1;
    @(posedge CORE_CLK) disable iff (!RST_N)
    rd_stat |=> RDATA[bfi_pkg::BIT_SUM1] == $past(IRQ_STATUS_1_ANY);
  endproperty
  a_sum1: assert property (p_sum1)
    else $error("bank 1 summary wrong");

  property p_talk_role;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (!DMA_REQUEST_N && !irq_enable_mask_0_r[bfi_pkg::BIT_LDMA]
      && $stable(irq_enable_mask_0_r)) |-> $past(HS.tacs);
  endproperty
  a_talk_role: assert property (p_talk_role)
    else $error("talker request outside talker role");

  property p_listen_dma;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (dma_master_enable_r && irq_enable_mask_0_r[bfi_pkg::BIT_LDMA] && full_r && !rd_data)
      |=> !DMA_REQUEST_N;
  endproperty
  a_listen_dma: assert property (p_listen_dma)
    else $error("listener request missing");

  property p_bi_clear;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (rd_data && !set_v[bfi_pkg::BIT_BI] && !pend_r[bfi_pkg::BIT_BI])
      |=> !flags_r[bfi_pkg::BIT_BI];
  endproperty
  a_bi_clear: assert property (p_bi_clear)
    else $error("byte-in not cleared by data read");

  property p_bo_clear;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (wr_data && !set_v[bfi_pkg::BIT_BO] && !pend_r[bfi_pkg::BIT_BO])
      |=> !flags_r[bfi_pkg::BIT_BO];
  endproperty
  a_bo_clear: assert property (p_bo_clear)
    else $error("byte-out not cleared by data write");

  property p_holdoff;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (hold_r && !rd_data) |=> $stable(din_r) && hold_r;
  endproperty
  a_holdoff: assert property (p_holdoff)
    else $error("byte taken during holdoff");

  property p_irq;
    @(posedge CORE_CLK) disable iff (!RST_N)
    // A data read or write may clear the only enabled flag
    (IRQ_STATUS_1_ANY || (sum0 && !rd_stat && !swrst && !rd_data && !wr_data && !wr_mask))
      |=> IRQ;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output missing");

  property p_irq_low;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (rd_stat && !IRQ_STATUS_1_ANY) |=> !IRQ;
  endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("interrupt output stuck after status read");

  property p_talk_dma;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (dma_master_enable_r && irq_enable_mask_0_r[bfi_pkg::BIT_TDMA] && HS.tacs && !nba_r && !wr_data)
      |=> !DMA_REQUEST_N;
  endproperty
  a_talk_dma: assert property (p_talk_dma)
    else $error("talker request missing");

  property p_bi_set;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (capture && !cont_r && !rd_stat) |=> flags_r[bfi_pkg::BIT_BI];
  endproperty
  a_bi_set: assert property (p_bi_set)
    else $error("byte-in not set on capture");

  property p_bo_set;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (bo_cond && !bo_cond_r && !rd_stat) |=> flags_r[bfi_pkg::BIT_BO];
  endproperty
  a_bo_set: assert property (p_bo_set)
    else $error("byte-out not set on generate state");

  property p_swrst_clear;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (swrst && set_v == '0 && pend_r == '0) |=> flags_r == '0;
  endproperty
  a_swrst_clear: assert property (p_swrst_clear)
    else $error("software reset left a flag set");

  property p_capture;
    @(posedge CORE_CLK) disable iff (!RST_N)
    capture |=> din_r == $past(DIO_IN);
  endproperty
  a_capture: assert property (p_capture)
    else $error("bus byte not captured");
endmodule

// >>> bfi_far_model.sv
// Far-side handshake model feeding the byte-flow status bank
module bfi_far_model (
  input  wire logic          core_clk,
  input  wire logic          out_valid,
  output bfi_pkg::bfi_hs_type hs,
  output logic [7:0]         dio_in,
  output logic               out_taken,
  output logic               irq_status_1_any
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hold;
  initial begin
    hs = '0;
    hold = 1'b1;
  end
  // ----------------------------------------------------------------
  // Source handshake: takes a pending byte unless stalled
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    out_taken <= 1'b0;
    if (out_valid && hs.tacs && hs.sgns && !hold) begin
      hs.sgns   <= 1'b0;
      out_taken <= 1'b1;
    end else if (hs.tacs && !hs.sgns) begin
      hs.sgns <= 1'b1;
    end
  end
  task automatic capture(input logic [7:0] b);
    @(posedge core_clk);
    hs.lacs <= 1'b1;
    hs.acds <= 1'b1;
    dio_in  <= b;
    @(posedge core_clk);
    hs.acds <= 1'b0;
    dio_in  <= ~b; // Released lines must not keep the byte
  endtask
  task automatic talk(input logic on);
    @(posedge core_clk);
    hs.tacs <= on;
    hs.sgns <= on;
  endtask
  task automatic bank1(input logic v);
    @(posedge core_clk);
    irq_status_1_any <= v;
  endtask
endmodule

// >>> tb.sv
// Self-checking bench for the byte-flow status bank 0 block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    bfi_pkg::bfi_evt_type evt;
    logic [7:0]           mask;
    logic [7:0]           stat;
    logic                 irq;
  } bfi_row_type;
  localparam bfi_row_type ROWS [5] = '{'{4'h1, 8'h01, 8'h81, 1'b1},
    '{4'h2, 8'h02, 8'h82, 1'b1}, '{4'h4, 8'h04, 8'h84, 1'b1},
    '{4'h8, 8'h08, 8'h88, 1'b1}, '{4'h2, 8'h3d, 8'h02, 1'b0}};
  logic                       core_clk, rst_n, wr_s, rd_s;
  logic [bfi_pkg::AW-1:0]     addr;
  logic [7:0]                 wdata, rdata, out_data;
  bfi_pkg::bfi_evt_type       evt;
  bfi_pkg::bfi_hs_type        hs;
  logic [7:0]                 dio_in;
  logic                       out_taken, irq_status_1_any, out_valid, holdoff, irq, dma_n;
  int                         errors, samples_checked, i;
  bfi_status_bank0 dut (.CORE_CLK(core_clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr_s), .RD(rd_s), .RDATA(rdata), .HS(hs), .EVT(evt), .DIO_IN(dio_in),
    .OUT_TAKEN(out_taken), .IRQ_STATUS_1_ANY(irq_status_1_any), .OUT_DATA(out_data),
    .OUT_VALID(out_valid), .RFD_HOLDOFF(holdoff), .IRQ(irq), .DMA_REQUEST_N(dma_n));
  bfi_far_model ptn (.core_clk(core_clk), .out_valid(out_valid), .hs(hs),
    .dio_in(dio_in), .out_taken(out_taken), .irq_status_1_any(irq_status_1_any));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------
  // Bus master, comparison and closing tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge core_clk);
    wr_s  <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge core_clk);
    wr_s <= 1'b0;
    @(negedge core_clk);
  endtask
  // Event may ride along with the read strobe
  task automatic rchk(input logic [2:0] a, input bfi_pkg::bfi_evt_type e, input logic [7:0] x);
    @(posedge core_clk);
    rd_s <= 1'b1;
    addr <= a;
    evt  <= e;
    @(posedge core_clk);
    rd_s <= 1'b0;
    evt  <= '0;
    @(negedge core_clk);
    chk(rdata, x);
  endtask
  task automatic pulse(input bfi_pkg::bfi_evt_type e);
    @(posedge core_clk);
    evt <= e;
    @(posedge core_clk);
    evt <= '0;
    @(negedge core_clk);
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    $display("ERROR t=%0t run did not finish", $time);
    end_sim();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, wr_s, rd_s, evt} = '0;
    errors = 0;
    samples_checked = 0;
    ptn.bank1(1'b0);
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk(rdata, 8'h00);
    chk(out_data, 8'h00);
    chk({out_valid, holdoff, irq, dma_n}, 8'h01);
    @(posedge core_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 5; i++) begin
      wr(bfi_pkg::ADDR_MASK0, ROWS[i].mask);
      pulse(ROWS[i].evt);
      chk(irq, ROWS[i].irq);
      rchk(bfi_pkg::ADDR_STATUS0, '0, ROWS[i].stat);
      rchk(bfi_pkg::ADDR_STATUS0, '0, 8'h00);
    end
    $display("table rows done");
    ptn.bank1(1'b1);
    tick(2);
    chk(irq, 1'b1);
    rchk(bfi_pkg::ADDR_STATUS0, '0, 8'h40);
    ptn.bank1(1'b0);
    wr(bfi_pkg::ADDR_MASK0, 8'h20);
    ptn.capture(8'ha5);
    tick(1);
    chk(holdoff, 1'b1);
    rchk(bfi_pkg::ADDR_STATUS0, '0, 8'ha0);
    ptn.capture(8'h3c);
    tick(1);
    rchk(bfi_pkg::ADDR_STATUS0, '0, 8'h00);
    rchk(bfi_pkg::ADDR_DATA, '0, 8'ha5);
    chk(holdoff, 1'b0);
    ptn.capture(8'h3c);
    tick(1);
    rchk(bfi_pkg::ADDR_DATA, '0, 8'h3c);
    rchk(bfi_pkg::ADDR_STATUS0, '0, 8'h00);
    wr(bfi_pkg::ADDR_AUXCTL, 8'h02);
    ptn.capture(8'h11);
    tick(1);
    rchk(bfi_pkg::ADDR_STATUS0, '0, 8'h00);
    rchk(bfi_pkg::ADDR_DATA, '0, 8'h11);
    wr(bfi_pkg::ADDR_AUXCTL, 8'h00);
    wr(bfi_pkg::ADDR_MASK0, 8'h01);
    rchk(bfi_pkg::ADDR_STATUS0, 4'h1, 8'h00);
    rchk(bfi_pkg::ADDR_STATUS0, '0, 8'h81);
    $display("byte-in and deferred set done");
    wr(bfi_pkg::ADDR_AUXCTL, 8'h01);
    wr(bfi_pkg::ADDR_MASK0, 8'h80);
    ptn.talk(1'b1);
    tick(3);
    chk(dma_n, 1'b0);
    wr(bfi_pkg::ADDR_DATA, 8'h5a);
    chk(out_data, 8'h5a);
    chk(out_valid, 1'b1);
    tick(1);
    chk(dma_n, 1'b1);
    rchk(bfi_pkg::ADDR_STATUS0, '0, 8'h00);
    ptn.hold = 1'b0;
    for (i = 0; i < 20 && out_valid !== 1'b0; i++) tick(1);
    chk(out_valid, 1'b0);
    tick(2);
    rchk(bfi_pkg::ADDR_STATUS0, '0, 8'h10);
    ptn.talk(1'b0);
    tick(2);
    chk(dma_n, 1'b1);
    wr(bfi_pkg::ADDR_MASK0, 8'h40);
    ptn.capture(8'h77);
    tick(2);
    chk(dma_n, 1'b0);
    rchk(bfi_pkg::ADDR_DATA, '0, 8'h77);
    tick(1);
    chk(dma_n, 1'b1);
    wr(bfi_pkg::ADDR_MASK0, 8'h00);
    wr(bfi_pkg::ADDR_AUXCTL, 8'h00);
    $display("dma done");
    pulse(4'h2);
    ptn.capture(8'h12);
    wr(bfi_pkg::ADDR_AUXCTL, 8'h04);
    rchk(bfi_pkg::ADDR_STATUS0, '0, 8'h00);
    rchk(bfi_pkg::ADDR_AUXCTL, '0, 8'h28);
    rchk(3'h7, '0, 8'h00);
    wr(bfi_pkg::ADDR_AUXCTL, 8'h01);
    wr(bfi_pkg::ADDR_MASK0, 8'hff);
    ptn.talk(1'b1);
    tick(3);
    chk(dma_n, 1'b0);
    @(posedge core_clk);
    rst_n <= 1'b0;
    tick(2);
    @(posedge core_clk);
    rst_n <= 1'b1;
    wr(bfi_pkg::ADDR_AUXCTL, 8'h01);
    tick(3);
    chk({dma_n, irq}, 8'h02);
    chk(holdoff, 1'b0);
    $display("swrst and second reset done");
    end_sim();
  end
endmodule
